// File: lms_pkg.sv
// constants shared by the locomotive motor speed control block
// assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data
package lms_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned PWM_HZ         = 25_000;
  localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
  localparam logic [11:0] PWM_PERIOD     = 12'(PWM_PERIOD_CYC);
  localparam int unsigned RAMP_TICK_US   = 1_000;
  localparam int unsigned RAMP_TICK_CYC  = (CLK_HZ / 1_000_000) * RAMP_TICK_US;
  localparam int unsigned BLINK_MS       = 250;
  localparam int unsigned BLINK_CYC      = (CLK_HZ / 1_000) * BLINK_MS;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_FMAP   = 8'h04;
  localparam logic [7:0] REG_CURVE  = 8'h08;
  localparam logic [7:0] REG_PID    = 8'h0C;
  localparam logic [7:0] REG_RAMP   = 8'h10;
  localparam logic [7:0] REG_OVLD   = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_ALT    = 8'h40;
  localparam int unsigned ALT_STEPS = 28;
  localparam logic [7:0] REG_ALT_END = 8'hAC;

  // ==========================================================================
  // control register fields
  localparam int unsigned CTRL_LOAD_EN  = 0;
  localparam int unsigned CTRL_ALT_EN   = 1;
  localparam int unsigned CTRL_MODE_LO  = 2;
  localparam int unsigned CTRL_KICK_EN  = 4;
  localparam int unsigned CTRL_CBRK_EN  = 5;
  localparam int unsigned CTRL_ASYM_EN  = 6;
  localparam int unsigned CTRL_ASYM_NEG = 7;
  localparam logic [1:0]  MODE_14       = 2'h0;
  localparam logic [1:0]  MODE_28       = 2'h1;

  // ==========================================================================
  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
  localparam logic [31:0] FMAP_RST  = 32'h0010_0008;
  localparam logic [31:0] CURVE_RST = 32'h00FF_8010;
  localparam logic [31:0] PID_RST   = 32'h2002_0410;
  localparam logic [31:0] RAMP_RST  = 32'h0A60_0505;
  localparam logic [31:0] OVLD_RST  = 32'h0000_0800;

  // ==========================================================================
  // speed level scaling, regulator arithmetic and bus response codes
  localparam logic [6:0] TOP_14    = 7'h0E;
  localparam logic [6:0] TOP_28    = 7'h1C;
  localparam logic [6:0] TOP_128   = 7'h7E;
  localparam logic [4:0] SCALE_14  = 5'h12;
  localparam logic [4:0] SCALE_28  = 5'h09;
  localparam logic [4:0] SCALE_128 = 5'h02;
  localparam int unsigned GAIN_SHIFT = 5;
  localparam int unsigned PID_SHIFT  = 4;
  localparam logic signed [15:0] INTEG_MAX = 16'sh0FFF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : lms_pkg

// File: lms_motor_ctrl.sv
// motor speed control of a locomotive decoder: pwm drive, load control,
// speed curves, ramps, asymmetric track braking and overload latch
// assumes an AXI4-Lite master, synchronous inputs and aresetn at power-on
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - on total overload or motor short, cut motor drive and flash lights
// - after overload stay stopped until power is removed and restored
// - overload current threshold is set by a sensitivity setting
// - single output overcurrent alone never trips the overload shutdown
// - motor is driven by pwm at a 25 kHz carrier
// - load control switchable, holds speed constant under varying load
// - regulator uses proportional, integral, derivative terms, each configurable
// - measured motor back voltage is scaled by a configurable gain
// - default curve interpolates linearly between start, middle and maximum
// - in 28 step mode an optional table gives each step its voltage
// - optional starting kick, then ramp to the selected step voltage
// - shunting mode halves the velocity of every speed step
// - shunting toggled by mapped functions, factory mapped to F3
// - ramping switched by mapped functions, factory mapped to F4
// - ramping moves one level per dwell, separate accel and brake dwell
// - constant distance braking stretches dwell when braking below top
// - larger brake rate value gives longer braking distance
// - asymmetric track voltage, when enabled, brakes the locomotive to stop
// - setting selects negative or positive half wave for asymmetric detection
// - functions, config writes and direction stay live while braking section
// - on leaving the section accelerate with accel dwell to commanded step
module lms_motor_ctrl
  import lms_pkg::*;
#(
  parameter int unsigned RAMP_TICK  = RAMP_TICK_CYC,
  parameter int unsigned BLINK_TICK = BLINK_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [6:0]  speed_step,
  input  wire logic        drive_dir,
  input  wire logic [15:0] func_state,
  input  wire logic        light_front_req,
  input  wire logic        light_rear_req,
  input  wire logic [11:0] total_current,
  input  wire logic [9:0]  bemf_sample,
  input  wire logic        bemf_valid,
  input  wire logic        asym_neg_seen,
  input  wire logic        asym_pos_seen,
  output var  logic        pwm_out,
  output var  logic        motor_dir,
  output var  logic        front_light_output,
  output var  logic        rear_light_output
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [31:0]            ctrl;
    logic [31:0]            fmap;
    logic [31:0]            curve;
    logic [31:0]            pid;
    logic [31:0]            ramp;
    logic [31:0]            ovld_cfg;
    logic [27:0][7:0]       alt;
    logic [7:0]             awaddr;
    logic                   aw_full;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   w_full;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   ovld;
    logic [31:0]            blink_cnt;
    logic                   blink;
    logic [31:0]            tick_cnt;
    logic [6:0]             level;
    logic [15:0]            acc;
    logic                   braking;
    logic [6:0]             brake_from;
    logic                   asym_ramp;
    logic [7:0]             kick_cnt;
    logic signed [15:0]     integ;
    logic signed [9:0]      prev_err;
    logic [7:0]             duty;
    logic [11:0]            pwm_cnt;
    logic                   pwm;
    logic                   dir;
    logic                   lf;
    logic                   lr;
  } lms_state_t;

  lms_state_t s_r;
  lms_state_t s_nxt;

  // ==========================================================================
  // helpers
  function automatic logic [31:0] lms_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : lms_merge

  logic              tick;
  logic              shunt_on;
  logic              ramp_fn_on;
  logic              asym_active;
  logic              ramp_on;
  logic [6:0]        top_lvl;
  logic [4:0]        scale;
  logic [6:0]        target;
  logic [11:0]       pos_raw;
  logic [7:0]        pos;
  logic [7:0]        seg_base;
  logic [7:0]        seg_end;
  logic signed [9:0] seg_diff;
  logic signed [17:0] seg_prod;
  logic signed [9:0] v_lin;
  logic [7:0]        v_set;
  logic [7:0]        v_drv;
  logic [15:0]       inc;
  logic [15:0]       thr;
  logic [17:0]       meas_prod;
  logic [7:0]        meas;
  logic signed [9:0] err;
  logic signed [15:0] integ_sum;
  logic signed [10:0] deriv;
  logic signed [27:0] corr;
  logic signed [27:0] duty_raw;
  logic [19:0]       pwm_prod;
  logic [7:0]        rd_idx;

  always_comb begin
    s_nxt = s_r;

    // ========================================================================
    // modes from mapped functions and track sensing
    shunt_on   = |(func_state & s_r.fmap[15:0]);
    ramp_fn_on = |(func_state & s_r.fmap[31:16]);
    asym_active = s_r.ctrl[CTRL_ASYM_EN] &&
                  (s_r.ctrl[CTRL_ASYM_NEG] ? asym_neg_seen : asym_pos_seen);
    case (s_r.ctrl[CTRL_MODE_LO +: 2])
      MODE_14: begin
        top_lvl = TOP_14;
        scale   = SCALE_14;
      end
      MODE_28: begin
        top_lvl = TOP_28;
        scale   = SCALE_28;
      end
      default: begin
        top_lvl = TOP_128;
        scale   = SCALE_128;
      end
    endcase
    target = asym_active ? 7'h00 : ((speed_step > top_lvl) ? top_lvl : speed_step);
    if (asym_active) begin
      s_nxt.asym_ramp = 1'b1;
    end else if (s_r.level == target) begin
      s_nxt.asym_ramp = 1'b0;
    end
    // braking into and pulling out of a section always uses the ramps
    ramp_on = ramp_fn_on || asym_active || s_r.asym_ramp;

    // ========================================================================
    // register bus: write path, address and data taken in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.awaddr  = s_axi_awaddr;
      s_nxt.aw_full = 1'b1;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
      s_nxt.w_full = 1'b1;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // config writes are never blocked, also inside a braking section
    if (s_r.aw_full && s_r.w_full && !s_r.bvalid) begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_OKAY;
      case ({s_r.awaddr[7:2], 2'b00})
        REG_CTRL:   s_nxt.ctrl     = lms_merge(s_r.ctrl, s_r.wdata, s_r.wstrb);
        REG_FMAP:   s_nxt.fmap     = lms_merge(s_r.fmap, s_r.wdata, s_r.wstrb);
        REG_CURVE:  s_nxt.curve    = lms_merge(s_r.curve, s_r.wdata, s_r.wstrb);
        REG_PID:    s_nxt.pid      = lms_merge(s_r.pid, s_r.wdata, s_r.wstrb);
        REG_RAMP:   s_nxt.ramp     = lms_merge(s_r.ramp, s_r.wdata, s_r.wstrb);
        REG_OVLD:   s_nxt.ovld_cfg = lms_merge(s_r.ovld_cfg, s_r.wdata, s_r.wstrb);
        REG_STATUS: s_nxt.bresp    = RESP_OKAY;
        default: begin
          if (s_r.awaddr >= REG_ALT && s_r.awaddr <= REG_ALT_END) begin
            if (s_r.wstrb[0]) begin
              s_nxt.alt[5'((s_r.awaddr - REG_ALT) >> 2)] = s_r.wdata[7:0];
            end
          end else begin
            s_nxt.bresp = RESP_SLVERR;
          end
        end
      endcase
    end
    s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_full && !s_nxt.bvalid;

    // ========================================================================
    // register bus: read path, answer on the edge after acceptance
    rd_idx = 8'((s_axi_araddr - REG_ALT) >> 2);
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        REG_CTRL:   s_nxt.rdata = s_r.ctrl;
        REG_FMAP:   s_nxt.rdata = s_r.fmap;
        REG_CURVE:  s_nxt.rdata = s_r.curve;
        REG_PID:    s_nxt.rdata = s_r.pid;
        REG_RAMP:   s_nxt.rdata = s_r.ramp;
        REG_OVLD:   s_nxt.rdata = s_r.ovld_cfg;
        REG_STATUS: s_nxt.rdata = {9'h000, s_r.level, s_r.duty, 4'h0, s_r.asym_ramp,
                                   ramp_on, shunt_on, s_r.ovld};
        default: begin
          if (s_axi_araddr >= REG_ALT && s_axi_araddr <= REG_ALT_END) begin
            s_nxt.rdata = {24'h000000, s_r.alt[rd_idx[4:0]]};
          end else begin
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.rresp = RESP_SLVERR;
          end
        end
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;

    // ========================================================================
    // ramp generator, one level per dwell
    tick = (s_r.tick_cnt >= RAMP_TICK - 1);
    s_nxt.tick_cnt = tick ? 32'h0000_0000 : s_r.tick_cnt + 32'h0000_0001;
    inc = 16'(top_lvl);
    thr = 16'h0000;
    if (s_r.level == target) begin
      s_nxt.acc     = 16'h0000;
      s_nxt.braking = 1'b0;
    end else if (!ramp_on) begin
      s_nxt.level = target;
      s_nxt.acc   = 16'h0000;
    end else if (tick) begin
      if (target > s_r.level) begin
        s_nxt.braking = 1'b0;
        thr = 16'(s_r.ramp[7:0] * top_lvl);
        inc = 16'(top_lvl);
      end else begin
        // constant distance: total time is brake value times top, wherever it starts
        if (!s_r.braking) begin
          s_nxt.braking    = 1'b1;
          s_nxt.brake_from = s_r.level;
        end
        thr = 16'(s_r.ramp[15:8] * top_lvl);
        inc = s_r.ctrl[CTRL_CBRK_EN] ?
              16'(s_r.braking ? s_r.brake_from : s_r.level) : 16'(top_lvl);
      end
      if (s_r.acc + inc >= thr) begin
        s_nxt.acc   = 16'h0000;
        s_nxt.level = (target > s_r.level) ? s_r.level + 7'h01 : s_r.level - 7'h01;
      end else begin
        s_nxt.acc = s_r.acc + inc;
      end
    end

    // starting kick from standstill, then the normal ramp takes over
    if (s_r.level == 7'h00 && s_nxt.level != 7'h00 && s_r.ctrl[CTRL_KICK_EN]) begin
      s_nxt.kick_cnt = s_r.ramp[31:24];
    end else if (tick && s_r.kick_cnt != 8'h00) begin
      s_nxt.kick_cnt = s_r.kick_cnt - 8'h01;
    end
    if (s_nxt.level == 7'h00) begin
      s_nxt.kick_cnt = 8'h00;
    end

    // ========================================================================
    // speed curve
    pos_raw = 12'(s_r.level * scale);
    pos     = (pos_raw > 12'h0FF) ? 8'hFF : pos_raw[7:0];
    if (!pos[7]) begin
      seg_base = s_r.curve[7:0];
      seg_end  = s_r.curve[15:8];
    end else begin
      seg_base = s_r.curve[15:8];
      seg_end  = s_r.curve[23:16];
    end
    seg_diff = $signed({2'b00, seg_end}) - $signed({2'b00, seg_base});
    seg_prod = 18'(seg_diff * $signed({1'b0, pos[6:0]}));
    v_lin    = $signed({2'b00, seg_base}) + 10'(seg_prod >>> 7);
    if (s_r.level == 7'h00) begin
      v_set = 8'h00;
    end else if (s_r.ctrl[CTRL_ALT_EN] && s_r.ctrl[CTRL_MODE_LO +: 2] == MODE_28) begin
      v_set = s_r.alt[5'(s_r.level - 7'h01)];
    end else begin
      v_set = (v_lin < 0) ? 8'h00 : ((v_lin > 10'sd255) ? 8'hFF : v_lin[7:0]);
    end
    v_drv = shunt_on ? (v_set >> 1) : v_set;
    if (s_r.kick_cnt != 8'h00) begin
      v_drv = s_r.ramp[23:16];
    end

    // ========================================================================
    // load regulator, updated once per back voltage sample
    meas_prod = 18'(bemf_sample * s_r.pid[31:24]);
    meas      = (meas_prod >> GAIN_SHIFT > 18'h000FF) ? 8'hFF : 8'(meas_prod >> GAIN_SHIFT);
    err       = $signed({2'b00, v_drv}) - $signed({2'b00, meas});
    integ_sum = s_r.integ + 16'(err);
    if (integ_sum > INTEG_MAX) begin
      integ_sum = INTEG_MAX;
    end else if (integ_sum < -INTEG_MAX) begin
      integ_sum = -INTEG_MAX;
    end
    deriv = 11'(err) - 11'(s_r.prev_err);
    corr  = 28'($signed({1'b0, s_r.pid[7:0]}) * err) +
            28'($signed({1'b0, s_r.pid[15:8]}) * integ_sum) +
            28'($signed({1'b0, s_r.pid[23:16]}) * deriv);
    duty_raw = 28'($signed({1'b0, v_drv})) + (corr >>> PID_SHIFT);
    if (s_r.ovld) begin
      s_nxt.duty  = 8'h00;
      s_nxt.integ = 16'sh0000;
    end else if (v_drv == 8'h00) begin
      s_nxt.duty     = 8'h00;
      s_nxt.integ    = 16'sh0000;
      s_nxt.prev_err = 10'sh000;
    end else if (!s_r.ctrl[CTRL_LOAD_EN]) begin
      s_nxt.duty = v_drv;
    end else if (bemf_valid) begin
      s_nxt.integ    = integ_sum;
      s_nxt.prev_err = err;
      s_nxt.duty     = (duty_raw < 0) ? 8'h00 :
                       ((duty_raw > 28'sd255) ? 8'hFF : duty_raw[7:0]);
    end

    // ========================================================================
    // overload latch: only the summed current counts, never a single output
    if (total_current > s_r.ovld_cfg[11:0]) begin
      s_nxt.ovld = 1'b1;
    end

    // ========================================================================
    // pwm carrier and outputs
    s_nxt.pwm_cnt = (s_r.pwm_cnt >= PWM_PERIOD - 12'h001) ? 12'h000 :
                    s_r.pwm_cnt + 12'h001;
    pwm_prod  = 20'(s_r.duty * PWM_PERIOD);
    s_nxt.pwm = !s_r.ovld && (s_r.pwm_cnt < pwm_prod[19:8]);
    s_nxt.dir = drive_dir;
    if (s_r.blink_cnt >= BLINK_TICK - 1) begin
      s_nxt.blink_cnt = 32'h0000_0000;
      s_nxt.blink     = !s_r.blink;
    end else begin
      s_nxt.blink_cnt = s_r.blink_cnt + 32'h0000_0001;
    end
    s_nxt.lf = s_r.ovld ? s_r.blink : light_front_req;
    s_nxt.lr = s_r.ovld ? s_r.blink : light_rear_req;
  end

  // ==========================================================================
  // registers; reset is power-on, the only way out of overload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r          <= '0;
      s_r.ctrl     <= CTRL_RST;
      s_r.fmap     <= FMAP_RST;
      s_r.curve    <= CURVE_RST;
      s_r.pid      <= PID_RST;
      s_r.ramp     <= RAMP_RST;
      s_r.ovld_cfg <= OVLD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready      = s_r.awready;
  assign s_axi_wready       = s_r.wready;
  assign s_axi_bvalid       = s_r.bvalid;
  assign s_axi_bresp        = s_r.bresp;
  assign s_axi_arready      = s_r.arready;
  assign s_axi_rvalid       = s_r.rvalid;
  assign s_axi_rdata        = s_r.rdata;
  assign s_axi_rresp        = s_r.rresp;
  assign pwm_out            = s_r.pwm;
  assign motor_dir          = s_r.dir;
  assign front_light_output = s_r.lf;
  assign rear_light_output  = s_r.lr;

endmodule : lms_motor_ctrl

`default_nettype wire

// File: lms_asserts.sv
// port checker of the motor control block
// bound to lms_motor_ctrl, single aclk domain
`timescale 1ns/100ps
`default_nettype none
module lms_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [11:0] total_current,
  input wire logic        drive_dir,
  input wire logic        pwm_out,
  input wire logic        motor_dir
);
  // ====================
  // helpers
  logic ov_r;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // full scale current trips any threshold the bench programs
  always_ff @(posedge aclk) begin
    if (!aresetn) ov_r <= 1'b0;
    else if (total_current == 12'hFFF) ov_r <= 1'b1;
  end
  // ====================
  // properties
  a_write_resp: assert property (s_wr |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_resp: assert property (s_rd |=> s_axi_rvalid) else $error("no read data");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read data dropped");
  a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlapped");
  a_ovld_off: assert property (ov_r |=> !pwm_out) else $error("drive after overload");
  a_dir_follow: assert property ($changed(drive_dir) |=> motor_dir == $past(drive_dir))
    else $error("direction not followed");
endmodule : lms_asserts
bind lms_motor_ctrl lms_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp), .total_current(total_current),
  .drive_dir(drive_dir), .pwm_out(pwm_out), .motor_dir(motor_dir));
`default_nettype wire

// File: lms_motor_model.sv
// dc motor model: back voltage follows average pwm drive minus load
// one sample per carrier period, assumes the 4000 cycle period
`timescale 1ns/100ps
`default_nettype none
module lms_motor_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       pwm_out,
  input  wire logic [3:0] load,
  output var  logic [9:0] bemf_sample,
  output var  logic       bemf_valid
);
  logic [11:0] cnt, hi;
  always_ff @(posedge aclk) begin
    bemf_valid <= 1'b0;
    if (!aresetn) begin
      cnt <= 12'h000;
      hi <= 12'h000;
    end else if (cnt == 12'hF9F) begin
      cnt <= 12'h000;
      hi <= 12'h000;
      bemf_sample <= {2'h0, hi[11:4]} - {6'h00, load};
      bemf_valid <= 1'b1;
    end else begin
      cnt <= cnt + 12'h001;
      hi <= hi + {11'h000, pwm_out};
    end
  end
endmodule : lms_motor_model
`default_nettype wire

// File: tb_top.sv
// self checking bench of the motor control block
// drives registers over axi4-lite, motor side from lms_motor_model
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_top;
  import lms_pkg::*;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, dir, lf, lr, an, ap;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  rs;
  logic [6:0]  step;
  logic [15:0] fs;
  logic [11:0] cur;
  logic [3:0]  load;
  wire  logic  awr, wr, bv, arr, rv, pwm, mdir, fo, ro, bvl;
  wire  logic [1:0]  br, rr;
  wire  logic [9:0]  bs;
  wire  logic [31:0] rdat;
  int          fail_count, comparisons, seed, i, n;
  logic [31:0] rst [6] = '{CTRL_RST, FMAP_RST, CURVE_RST, PID_RST, RAMP_RST, OVLD_RST};
  lms_motor_ctrl #(.RAMP_TICK(10), .BLINK_TICK(8)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .speed_step(step), .drive_dir(dir), .func_state(fs),
    .light_front_req(lf), .light_rear_req(lr), .total_current(cur), .bemf_sample(bs),
    .bemf_valid(bvl), .asym_neg_seen(an), .asym_pos_seen(ap), .pwm_out(pwm),
    .motor_dir(mdir), .front_light_output(fo), .rear_light_output(ro));
  lms_motor_model mdl (.aclk(aclk), .aresetn(aresetn), .pwm_out(pwm), .load(load),
    .bemf_sample(bs), .bemf_valid(bvl));
  // ====================
  // helpers
  function automatic logic [7:0] shunt(input logic [7:0] v);
    return v >> 1;
  endfunction : shunt
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // one transfer, valid held until its own ready, answer taken with its valid
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awa <= a;
    ara <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    arv <= !w;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (arr) arv <= 1'b0;
      // late ready stalls the answer for the hold checks
      if (k == 2) {bry, rry} <= {w, !w};
      if ((bv && bry) || (rv && rry)) break;
    end
    bry <= 1'b0;
    rry <= 1'b0;
    rd = rdat;
    rs = w ? br : rr;
    if (k == 50) begin
      fail_count++;
      final_report();
    end
  endtask : bus
  task automatic st(input int c);
    repeat (c) @(posedge aclk);
    bus(1'b0, REG_STATUS, 32'h0);
  endtask : st
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // light requests stay random all run
  always @(posedge aclk) begin
    lf <= 1'($random(seed));
    lr <= 1'($random(seed));
  end
  // ====================
  // sequence
  initial begin
    {aresetn, awv, wv, bry, arv, rry, dir, an, ap} = '0;
    {awa, ara, wd, step, fs, cur, load} = '0;
    seed = 32'h64FC;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      `CHK("reset value", rst[i], rd)
    end
    bus(1'b0, 8'h30, 32'h0);
    `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {rs, rd})
    bus(1'b1, 8'h30, 32'h1);
    `CHK("unmapped write", RESP_SLVERR, rs)
    bus(1'b1, REG_CTRL, 32'h08);
    step <= 7'h40;
    st(3);
    `CHK("curve mid", {7'h40, CURVE_RST[15:8]}, {rd[22:16], rd[15:8]})
    fs <= 16'h0008;
    st(3);
    `CHK("shunting", shunt(CURVE_RST[15:8]), rd[15:8])
    fs <= 16'h0;
    n = $random(seed);
    bus(1'b1, 8'h50, {24'h0, 8'(n)});
    bus(1'b1, REG_CTRL, 32'h06);
    step <= 7'h05;
    st(3);
    `CHK("alt table", 8'(n), rd[15:8])
    bus(1'b1, REG_RAMP, 32'h0A60_0202);
    bus(1'b1, REG_CTRL, 32'h34);
    fs <= 16'h0010;
    step <= 7'h00;
    st(300);
    `CHK("long brake", 1'b1, rd[22:16] != 7'h0)
    st(500);
    `CHK("stopped", 7'h0, rd[22:16])
    step <= 7'h05;
    st(20);
    `CHK("accel", 1'b1, rd[22:16] < 7'h05 && rd[2])
    `CHK("kick", 8'h60, rd[15:8])
    st(200);
    `CHK("accel done", 7'h05, rd[22:16])
    fs <= 16'h0;
    bus(1'b1, REG_CTRL, 32'hC4);
    ap <= 1'b1;
    st(200);
    `CHK("other wave", 7'h05, rd[22:16])
    an <= 1'b1;
    dir <= 1'b1;
    st(300);
    `CHK("asym stop", 7'h0, rd[22:16])
    {an, ap} <= 2'b00;
    st(300);
    `CHK("asym release", 7'h05, rd[22:16])
    bus(1'b1, REG_CTRL, 32'h44);
    ap <= 1'b1;
    st(300);
    `CHK("pos wave", 7'h0, rd[22:16])
    ap <= 1'b0;
    // kp stays at its nonzero reset value
    bus(1'b1, REG_CTRL, 32'h05);
    load <= 4'($random(seed));
    st(9000);
    `CHK("load duty", 1'b1, rd[15:8] != 8'h0)
    bus(1'b1, REG_OVLD, 32'h100);
    cur <= 12'h100;
    st(3);
    `CHK("at threshold", 1'b0, rd[0])
    cur <= 12'hFFF;
    @(posedge aclk);
    cur <= 12'h0;
    st(3);
    `CHK("latched", 1'b1, rd[0])
    n = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      n = n | (fo ? 1 : 2);
      `CHK("drive off", 2'b0, {pwm, ro ^ fo})
    end
    `CHK("blink", 3, n)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    st(2);
    `CHK("latch cleared", 1'b0, rd[0])
    `CHK("direction", dir, mdir)
    for (i = 0; i < 9; i++) begin
      @(posedge aclk);
      if (i > 0) `CHK("lights", n[1:0], {ro, fo})
      n = int'({lr, lf});
    end
    final_report();
  end
endmodule : tb_top
`default_nettype wire
